// >>> scp_host.sv
// Serial host model driving frames into the register bank
`timescale 1ns/1ps
module scp_host (
   // Clock
   input wire logic clk,
   // Serial wire
   input wire logic sdio_o,
   input wire logic sdio_oe,
   output logic sclk,
   output logic csb_n,
   output wire logic sdio_i
);
   logic h_oe = 1'b0;
   logic h_d = 1'b0;
   initial sclk = 1'b0;
   initial csb_n = 1'b1;
   // Released wire shows the inverse of the last driven level, never the last one
   assign sdio_i = sdio_oe ? sdio_o : (h_oe ? h_d : ~h_d);
   task automatic bit_t(input logic d, input logic drv, output logic q);
      h_oe = drv;
      h_d = d;
      sclk = 1'b0;
      repeat (6) @(negedge clk);
      q = sdio_i;
      sclk = 1'b1;
      repeat (6) @(negedge clk);
   endtask
   // Host keeps to mapped addresses and the boot wait
   task automatic frame(input logic rw, input logic [14:0] a, input int nb,
      input logic [15:0] wd, input logic lsb, output logic [7:0] rd);
      logic [15:0] w;
      logic q;
      w = {rw, a};
      @(negedge clk);
      csb_n = 1'b0;
      for (int i = 0; i < 16; i++) begin
         bit_t(lsb ? w[i] : w[15-i], 1'b1, q);
      end
      w = (nb == 2) ? wd : {wd[7:0], 8'h00};
      for (int i = 0; i < 8 * nb; i++) begin
         bit_t(lsb ? w[8-8*(i/8)+i%8] : w[15-i], !rw, q);
         rd[lsb ? i % 8 : 7 - i % 8] = q;
      end
      csb_n = 1'b1;
      h_oe = 1'b0;
      repeat (3) @(negedge clk);
      sclk = 1'b0;
      repeat (6) @(negedge clk);
   endtask
endmodule

// >>> scp_pkg.sv
// Package for the serial configuration and power register bank
package scp_pkg;
   // -------------------------------------------------------------------
   // Register map
   // -------------------------------------------------------------------
   localparam int ADDR_W = 15;
   localparam logic [14:0] OFF_CFG_A = 15'h0000;
   localparam logic [14:0] OFF_CFG_B = 15'h0001;
   localparam logic [14:0] OFF_PWR = 15'h0002;
   localparam logic [14:0] OFF_CHAN_SEL = 15'h0008;
   // -------------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------------
   localparam int A_RST = 0;
   localparam int A_LSB = 1;
   localparam int A_ASC = 2;
   localparam int A_ASC_M = 5;
   localparam int A_LSB_M = 6;
   localparam int A_RST_M = 7;
   localparam int B_DP_RST = 1;
   // -------------------------------------------------------------------
   // Reset values and modes
   // -------------------------------------------------------------------
   localparam logic [7:0] CFG_A_RST = 8'h00;
   localparam logic [7:0] CFG_B_RST = 8'h00;
   localparam logic [1:0] PWR_RST = 2'h0;
   localparam logic [1:0] CHSEL_RST = 2'h3;
   localparam logic [1:0] PWR_NORMAL = 2'h0;
   localparam logic [1:0] PWR_STANDBY = 2'h2;
   localparam logic [1:0] PWR_DOWN = 2'h3;
   // -------------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------------
   localparam int CLK_MHZ = 50;
   localparam int BOOT_MS = 5;
   localparam int BOOT_CYC = BOOT_MS * 1000 * CLK_MHZ;
   localparam int DP_RST_CYC = 1;
   typedef enum logic [1:0] {ST_IDLE, ST_INSTR, ST_DATA} scp_state_t;
endpackage

// >>> scp_regs.sv
// Serial register port with configuration, soft reset and power control
`timescale 1ns/1ps
module scp_regs import scp_pkg::*; #(
   parameter int BOOT_CYCLES = BOOT_CYC
) (
   // System
   input wire logic CLK_SYS,
   input wire logic RSTN,
   // Serial port
   input wire logic SCLK,
   input wire logic CSB_N,
   input wire logic SDIO_I,
   output logic SDIO_O,
   output logic SDIO_OE,
   // Datapath control per channel, and boot busy flag
   output logic [1:0] DP_CLK_EN,
   output logic [1:0] DP_RESET,
   output logic [1:0] LINK_EN,
   output logic BOOT_BUSY
);
   // -------------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------------
   logic [2:0] s1_q, s2_q, s1_d, s2_d;
   logic sclk_old_q, sclk_old_d;
   always_comb begin
      s1_d = {SCLK, CSB_N, SDIO_I};
      s2_d = s1_q;
      sclk_old_d = s2_q[2];
   end
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         s1_q <= 3'h3;
         s2_q <= 3'h3;
         sclk_old_q <= 1'b0;
      end else begin
         s1_q <= s1_d;
         s2_q <= s2_d;
         sclk_old_q <= sclk_old_d;
      end
   end
   wire sclk_s = s2_q[2];
   wire csn_s = s2_q[1];
   wire sdi_s = s2_q[0];
   wire rise = sclk_s & ~sclk_old_q;
   wire fall = ~sclk_s & sclk_old_q;

   // -------------------------------------------------------------------
   // Registers and serial engine
   // -------------------------------------------------------------------
   // Primary bits hold state; mirrors are derived so they never disagree
   logic lsb_q, lsb_d, asc_q, asc_d;
   logic [1:0] pwr_a_q, pwr_a_d, pwr_b_q, pwr_b_d, chsel_q, chsel_d;
   logic [1:0] dprst_q, dprst_d;
   scp_state_t st_q, st_d;
   logic [4:0] cnt_q, cnt_d;
   logic [15:0] sh_q, sh_d;
   logic rd_q, rd_d;
   logic [14:0] addr_q, addr_d;
   logic oe_q, oe_d, sdo_q, sdo_d;
   logic [31:0] boot_q, boot_d;
   logic [7:0] wbyte, rbyte;
   logic [15:0] nsh;

   function automatic logic [7:0] read_reg(input logic [14:0] a,
         input logic ls, input logic as, input logic [1:0] pa,
         input logic [1:0] pb, input logic [1:0] cs);
      read_reg = 8'h00;
      unique case (a)
         OFF_CFG_A: read_reg = {1'b0, ls, as, 2'b00, as, ls, 1'b0};
         // Only B selected reads B; A otherwise, both selected included
         OFF_PWR: read_reg = {6'h00, (cs == 2'b10) ? pb : pa};
         OFF_CHAN_SEL: read_reg = {6'h00, cs};
         default: read_reg = 8'h00;
      endcase
   endfunction

   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      sh_d = sh_q;
      rd_d = rd_q;
      addr_d = addr_q;
      oe_d = oe_q;
      sdo_d = sdo_q;
      lsb_d = lsb_q;
      asc_d = asc_q;
      pwr_a_d = pwr_a_q;
      pwr_b_d = pwr_b_q;
      chsel_d = chsel_q;
      dprst_d = 2'b00;
      boot_d = (boot_q != 32'd0) ? boot_q - 32'd1 : 32'd0;
      // Shift in; LSB-first fills from the top so the byte still lands
      nsh = lsb_q ? {sdi_s, sh_q[15:1]} : {sh_q[14:0], sdi_s};
      wbyte = 8'h00;
      rbyte = read_reg(addr_q, lsb_q, asc_q, pwr_a_q, pwr_b_q, chsel_q);
      if (csn_s || boot_q != 32'd0) begin
         // Port held idle while the boot loader runs
         st_d = ST_INSTR;
         cnt_d = 5'd0;
         oe_d = 1'b0;
      end else if (rise) begin
         sh_d = nsh;
         cnt_d = cnt_q + 5'd1;
         if (st_q != ST_DATA && cnt_q == 5'd15) begin
            // Instruction: R/W flag then 15-bit address
            // Either order leaves R/W on top and the address below it
            rd_d = nsh[15];
            addr_d = nsh[14:0];
            st_d = ST_DATA;
            cnt_d = 5'd0;
         end else if (st_q == ST_DATA && cnt_q == 5'd7) begin
            cnt_d = 5'd0;
            wbyte = lsb_q ? nsh[15:8] : nsh[7:0];
            if (!rd_q) begin
               unique case (addr_q)
                  OFF_CFG_A: begin
                     if (wbyte[A_RST] || wbyte[A_RST_M]) begin
                        lsb_d = 1'b0;
                        asc_d = 1'b0;
                        pwr_a_d = PWR_RST;
                        pwr_b_d = PWR_RST;
                        chsel_d = CHSEL_RST;
                        boot_d = 32'(BOOT_CYCLES);
                        st_d = ST_IDLE;
                     end else begin
                        lsb_d = wbyte[A_LSB] | wbyte[A_LSB_M];
                        asc_d = wbyte[A_ASC] | wbyte[A_ASC_M];
                     end
                  end
                  OFF_CFG_B: if (wbyte[B_DP_RST]) dprst_d = chsel_q;
                  OFF_PWR: begin
                     if (chsel_q[0]) pwr_a_d = wbyte[1:0];
                     if (chsel_q[1]) pwr_b_d = wbyte[1:0];
                  end
                  OFF_CHAN_SEL: chsel_d = wbyte[1:0];
                  default: ; // Unmapped writes are dropped
               endcase
            end
            addr_d = asc_q ? addr_q + 15'd1 : addr_q - 15'd1;
         end
      end else if (fall && st_q == ST_DATA && rd_q) begin
         oe_d = 1'b1;
         sdo_d = lsb_q ? rbyte[cnt_q[2:0]] : rbyte[3'd7 - cnt_q[2:0]];
      end
   end

   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         st_q <= ST_IDLE;
         cnt_q <= 5'd0;
         sh_q <= 16'h0000;
         rd_q <= 1'b0;
         addr_q <= 15'h0000;
         oe_q <= 1'b0;
         sdo_q <= 1'b0;
         lsb_q <= CFG_A_RST[A_LSB];
         asc_q <= CFG_A_RST[A_ASC];
         pwr_a_q <= PWR_RST;
         pwr_b_q <= PWR_RST;
         chsel_q <= CHSEL_RST;
         dprst_q <= 2'b00;
         boot_q <= 32'd0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         sh_q <= sh_d;
         rd_q <= rd_d;
         addr_q <= addr_d;
         oe_q <= oe_d;
         sdo_q <= sdo_d;
         lsb_q <= lsb_d;
         asc_q <= asc_d;
         pwr_a_q <= pwr_a_d;
         pwr_b_q <= pwr_b_d;
         chsel_q <= chsel_d;
         dprst_q <= dprst_d;
         boot_q <= boot_d;
      end
   end

   // -------------------------------------------------------------------
   // Power mode decode
   // -------------------------------------------------------------------
   logic [1:0] clk_en_q, clk_en_d, rst_q, rst_d, link_q, link_d;
   logic busy_q, busy_d;
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         logic [1:0] m;
         m = (c == 0) ? pwr_a_q : pwr_b_q;
         clk_en_d[c] = (m == PWR_NORMAL);
         link_d[c] = (m != PWR_DOWN);
         rst_d[c] = (m == PWR_DOWN) | dprst_q[c] | (boot_q != 32'd0);
      end
      busy_d = (boot_q != 32'd0);
   end
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         clk_en_q <= 2'b11;
         rst_q <= 2'b00;
         link_q <= 2'b11;
         busy_q <= 1'b0;
      end else begin
         clk_en_q <= clk_en_d;
         rst_q <= rst_d;
         link_q <= link_d;
         busy_q <= busy_d;
      end
   end
   assign SDIO_O = sdo_q;
   assign SDIO_OE = oe_q;
   assign DP_CLK_EN = clk_en_q;
   assign DP_RESET = rst_q;
   assign LINK_EN = link_q;
   assign BOOT_BUSY = busy_q;
endmodule

// >>> scp_regs_sva.sv
// Assertion checker for the register bank
`timescale 1ns/1ps
module scp_regs_sva #(
   parameter int BOOT_CYCLES = 20
) (
   input wire logic CLK_SYS,
   input wire logic RSTN,
   input wire logic CSB_N,
   input wire logic SDIO_OE,
   input wire logic [1:0] DP_CLK_EN,
   input wire logic [1:0] DP_RESET,
   input wire logic [1:0] LINK_EN,
   input wire logic BOOT_BUSY
);
   // ----
   // Checks
   // ----
   int cnt_q;
   int cnt_d;
   always_comb cnt_d = BOOT_BUSY ? cnt_q + 1 : 0;
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) cnt_q <= 0;
      else cnt_q <= cnt_d;
   end
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RSTN);
   sequence s_cs_idle;
      CSB_N [*6];
   endsequence
   sequence s_boot_on;
      BOOT_BUSY ##1 BOOT_BUSY;
   endsequence
   chk_boot_len: assert property (cnt_q < BOOT_CYCLES + 4)
      else $error("boot too long");
   chk_boot_reset: assert property (s_boot_on |-> DP_RESET == 2'h3)
      else $error("datapath free in boot");
   chk_boot_mute: assert property (BOOT_BUSY |-> !SDIO_OE)
      else $error("drive in boot");
   chk_oe_release: assert property ($rose(CSB_N) |-> ##[1:5] !SDIO_OE)
      else $error("data pin held");
   chk_oe_quiet: assert property (s_cs_idle |-> !SDIO_OE)
      else $error("drive while idle");
   chk_dp_pulse: assert property ($rose(DP_RESET[0]) && DP_CLK_EN[0] &&
      !BOOT_BUSY |=> !DP_RESET[0])
      else $error("datapath reset long");
   chk_down_state: assert property (!LINK_EN[0] |->
      !DP_CLK_EN[0] && DP_RESET[0])
      else $error("down mode wrong");
   chk_clk_link: assert property ((DP_CLK_EN & ~LINK_EN) == 2'h0)
      else $error("clock on with link off");
endmodule
bind scp_regs scp_regs_sva #(.BOOT_CYCLES(BOOT_CYCLES)) scp_regs_sva_inst (.*);

// >>> spi_config_power_regs_tb.sv
// Testbench for the register bank
`timescale 1ns/1ps
module spi_config_power_regs_tb;
   import scp_pkg::*;
   localparam int BOOT = 20;
   logic CLK_SYS = 1'b0;
   logic RSTN = 1'b0;
   logic SCLK, CSB_N, SDIO_I, SDIO_O, SDIO_OE, BOOT_BUSY;
   logic [1:0] DP_CLK_EN, DP_RESET, LINK_EN;
   logic lsb = 1'b0;
   logic [7:0] rv;
   int failures = 0;
   int checked = 0;
   int pulses = 0;
   always #10 CLK_SYS = ~CLK_SYS;
   always @(posedge CLK_SYS) if (DP_RESET[0] && DP_CLK_EN[0]) pulses++;
   scp_regs #(.BOOT_CYCLES(BOOT)) scp_regs_inst (.*);
   scp_host scp_host_inst (.clk(CLK_SYS), .sdio_o(SDIO_O),
      .sdio_oe(SDIO_OE), .sclk(SCLK), .csb_n(CSB_N), .sdio_i(SDIO_I));
   // ----
   // Tasks
   // ----
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         failures++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [14:0] a, input int nb, input logic [15:0] d);
      scp_host_inst.frame(1'b0, a, nb, d, lsb, rv);
   endtask
   task automatic rd(input logic [14:0] a, input logic [7:0] e);
      scp_host_inst.frame(1'b1, a, 1, 16'h0000, lsb, rv);
      chk("read", e, rv);
   endtask
   task automatic outs(input logic [7:0] e);
      chk("outputs", e, {2'h0, DP_CLK_EN, DP_RESET, LINK_EN});
   endtask
   task automatic t_reset;
      rd(OFF_CFG_A, 8'h00);
      rd(OFF_CFG_B, 8'h00);
      rd(OFF_PWR, 8'h00);
      outs(8'h33);
   endtask
   task automatic t_power;
      wr(OFF_PWR, 1, 16'h0002);
      chk("standby", 8'h03, {4'h0, DP_CLK_EN, LINK_EN});
      wr(OFF_PWR, 1, 16'h00FF);
      outs(8'h0C);
      rd(OFF_PWR, 8'h03);
      wr(OFF_CHAN_SEL, 1, 16'h0001);
      wr(OFF_PWR, 1, 16'h0000);
      outs(8'h19);
      wr(OFF_CHAN_SEL, 1, 16'h0002);
      rd(OFF_PWR, 8'h03);
      wr(OFF_CHAN_SEL, 1, 16'h0003);
      rd(OFF_PWR, 8'h00);
      wr(OFF_PWR, 1, 16'h0000);
   endtask
   task automatic t_order;
      wr(OFF_CFG_A, 1, 16'h0042);
      lsb = 1'b1;
      rd(OFF_CFG_A, 8'h42);
      wr(OFF_PWR, 2, 16'h0200);
      chk("descend", 8'h03, {4'h0, DP_CLK_EN, LINK_EN});
      wr(OFF_CFG_A, 1, 16'h0066);
      wr(OFF_CFG_B, 2, 16'h0000);
      outs(8'h33);
      wr(OFF_CFG_A, 1, 16'h0000);
      lsb = 1'b0;
      rd(OFF_CFG_A, 8'h00);
   endtask
   task automatic t_dp;
      pulses = 0;
      wr(OFF_CFG_B, 1, 16'h0002);
      chk("pulses", 8'h01, pulses[7:0]);
      rd(OFF_CFG_B, 8'h00);
   endtask
   task automatic t_boot(input logic [7:0] v);
      wr(OFF_PWR, 1, 16'h0003);
      wr(OFF_CFG_A, 1, {8'h00, v});
      chk("busy on", 8'h01, {7'h0, BOOT_BUSY});
      repeat (BOOT + 5) @(negedge CLK_SYS);
      chk("busy", 8'h00, {7'h0, BOOT_BUSY});
      rd(OFF_PWR, 8'h00);
      rd(OFF_CFG_A, 8'h00);
      outs(8'h33);
   endtask
   task automatic summarize;
      if (failures == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #1000000;
      failures++;
      summarize();
   end
   initial begin
      repeat (5) @(negedge CLK_SYS);
      RSTN = 1'b1;
      repeat (4) @(negedge CLK_SYS);
      t_reset();
      t_power();
      t_order();
      t_dp();
      t_boot(8'h81);
      t_boot(8'h80);
      summarize();
   end
endmodule
